// ### verilog/dct_timer.sv
// Two 8-bit timers with two output-compare channels each.
// Assumes the CPU special function register port and timer tick share clk_sys.
`timescale 1ns/1ps
module dct_timer (
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  input  wire logic                 clk_en,
  input  wire logic                 timer_tick,
  input  wire dct_pkg::dct_sfr_req_t sfr_req,
  input  wire logic [1:0]           global_enable_per_timer,
  input  wire logic [1:0]           cpu_flag_clear,
  output wire logic [7:0]           sfr_rdata,
  output wire logic [1:0]           channel_out_a,
  output wire logic [1:0]           channel_out_b,
  output wire logic                 dma_trig_a0,
  output wire logic                 dma_trig_a1,
  output wire logic                 dma_trig_b0,
  output wire logic                 dma_trig_b1,
  output wire logic [1:0]           cpu_flag_per_timer,
  output wire logic                 irq_request_a,
  output wire logic                 irq_request_b
);

  // ------------------------------------------------------------------
  // Shared helpers
  // ------------------------------------------------------------------
  function automatic logic dct_hit(input logic [7:0] addr, input logic [7:0] base, input logic [7:0] off);
    dct_hit = (addr == (base + off));
  endfunction : dct_hit

  // Next output level for one channel; holds unless its action fires
  function automatic logic dct_action_next(
    input logic [2:0] act,
    input logic       cur,
    input logic       hit,
    input logic       down,
    input logic       zero,
    input logic       top
  );
    dct_action_next = cur;
    unique case (dct_pkg::dct_action_t'(act))
      dct_pkg::DCT_ACT_SET:      if (hit) dct_action_next = 1'b1;
      dct_pkg::DCT_ACT_CLEAR:    if (hit) dct_action_next = 1'b0;
      dct_pkg::DCT_ACT_TOGGLE:   if (hit) dct_action_next = ~cur;
      dct_pkg::DCT_ACT_UP_SET:
      begin
        if (zero) dct_action_next = 1'b0;
        else if (hit) dct_action_next = ~down;
      end
      dct_pkg::DCT_ACT_UP_CLEAR:
      begin
        if (zero) dct_action_next = 1'b1;
        else if (hit) dct_action_next = down;
      end
      dct_pkg::DCT_ACT_SET_TOP:
      begin
        if (hit) dct_action_next = 1'b1;
        else if (top) dct_action_next = 1'b0;
      end
      dct_pkg::DCT_ACT_CLR_ZERO:
      begin
        if (hit) dct_action_next = 1'b0;
        else if (zero) dct_action_next = 1'b1;
      end
      dct_pkg::DCT_ACT_NONE:     dct_action_next = cur;
    endcase
  endfunction : dct_action_next

  // ------------------------------------------------------------------
  // Cross-timer wires
  // ------------------------------------------------------------------
  logic [5:0] flags_reg;
  logic [5:0] flags_next;
  logic [1:0] cpu_flag_reg;
  logic [1:0] cpu_flag_next;
  logic [1:0] irq_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  wire  logic [1:0] ovf_ev;
  wire  logic [3:0] chf_ev;
  wire  logic [3:0] cmp_ev;
  wire  logic [1:0] cpu_set;
  wire  logic [7:0] rd_val [2];
  wire  logic       flag_wr;
  wire  logic       flag_rd;

  assign flag_wr = sfr_req.wr && (sfr_req.addr == dct_pkg::SHARED_FLAG_ADDR);
  assign flag_rd = (sfr_req.addr == dct_pkg::SHARED_FLAG_ADDR);

  // ------------------------------------------------------------------
  // Per-timer logic
  // ------------------------------------------------------------------
  for (genvar t = 0; t < 2; t++)
  begin : g_tmr
    localparam logic [7:0] BASE = (t == 0) ? dct_pkg::TIMER3_COUNT_VALUE_ADDR : dct_pkg::TIMER_B_BASE;

    logic [7:0] ctl_reg;
    logic [7:0] ctl_next;
    logic [7:0] cctl0_reg;
    logic [7:0] cctl1_reg;
    logic [7:0] cc0_reg;
    logic [7:0] cc1_reg;
    logic [7:0] cc1_pend_reg;
    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;
    logic       dir_reg;
    logic       dir_next;
    logic [1:0] out_reg;
    logic [1:0] out_next;
    logic [1:0] dma_reg;
    logic [7:0] step;
    logic       step_dir;
    logic       stepped_down;
    logic       ovf_step;
    wire  logic act_edge;
    wire  logic wr_ctl;
    wire  logic wr_cctl0;
    wire  logic wr_cctl1;
    wire  logic wr_cc0;
    wire  logic wr_cc1;
    wire  logic clr_req;
    wire  logic start_rise;
    wire  logic run;
    wire  logic moving;
    wire  logic hit0;
    wire  logic hit1;
    wire  logic at_zero;
    wire  logic at_top;
    wire  dct_pkg::dct_mode_t mode;

    assign wr_ctl   = sfr_req.wr && dct_hit(sfr_req.addr, BASE, dct_pkg::OFF_CONTROL);
    assign wr_cctl0 = sfr_req.wr && dct_hit(sfr_req.addr, BASE, dct_pkg::OFF_CH0_CTL);
    assign wr_cctl1 = sfr_req.wr && dct_hit(sfr_req.addr, BASE, dct_pkg::OFF_CH1_CTL);
    assign wr_cc0   = sfr_req.wr && dct_hit(sfr_req.addr, BASE, dct_pkg::OFF_CH0_CMP);
    assign wr_cc1   = sfr_req.wr && dct_hit(sfr_req.addr, BASE, dct_pkg::OFF_CH1_CMP);
    assign mode     = dct_pkg::dct_mode_t'(ctl_reg[dct_pkg::CTL_MODE_LSB +: 2]);
    assign run      = ctl_reg[dct_pkg::CTL_START_BIT];
    assign clr_req  = wr_ctl && sfr_req.wdata[dct_pkg::CTL_CLEAR_BIT];
    assign start_rise = wr_ctl && sfr_req.wdata[dct_pkg::CTL_START_BIT] && !run;

    // Clear bit always reads zero, so it is never stored
    assign ctl_next = wr_ctl ? (sfr_req.wdata & ~(8'h01 << dct_pkg::CTL_CLEAR_BIT)) : ctl_reg;

    dct_prescaler #(
      .W (dct_pkg::PRESCALE_W)
    ) u_pre (
      .clk_sys     (clk_sys),
      .rst_n       (rst_n),
      .clk_en      (clk_en),
      .run         (run),
      .tick        (timer_tick),
      .div         (ctl_reg[dct_pkg::CTL_DIV_LSB +: 3]),
      .active_edge (act_edge)
    );

    // Counter step for each mode
    always_comb
    begin
      step         = cnt_reg;
      step_dir     = dir_reg;
      stepped_down = 1'b0;
      ovf_step     = 1'b0;
      unique case (mode)
        dct_pkg::DCT_MODE_FREE:
        begin
          step     = cnt_reg + 8'h01;
          ovf_step = (step == dct_pkg::COUNT_TOP);
        end
        dct_pkg::DCT_MODE_MODULO:
        begin
          step     = (cnt_reg == cc0_reg) ? 8'h00 : cnt_reg + 8'h01;
          ovf_step = (step == cc0_reg);
        end
        dct_pkg::DCT_MODE_DOWN:
        begin
          // Terminal count holds at zero
          step         = (cnt_reg == 8'h00) ? 8'h00 : cnt_reg - 8'h01;
          stepped_down = 1'b1;
          ovf_step     = (cnt_reg != 8'h00) && (step == 8'h00);
        end
        dct_pkg::DCT_MODE_UPDOWN:
        begin
          if (!dir_reg && (cnt_reg >= cc0_reg) && (cnt_reg != 8'h00))
          begin
            step         = cnt_reg - 8'h01;
            step_dir     = 1'b1;
            stepped_down = 1'b1;
          end
          else if (dir_reg)
          begin
            step         = cnt_reg - 8'h01;
            stepped_down = 1'b1;
          end
          else if (cc0_reg == 8'h00)
            step = 8'h00;
          else
            step = cnt_reg + 8'h01;
          if (step == 8'h00)
          begin
            step_dir = 1'b0;
            ovf_step = 1'b1;
          end
        end
      endcase
    end

    assign moving  = act_edge && !clr_req;
    assign hit0    = moving && cctl0_reg[dct_pkg::CCTL_EN_BIT] && (step == cc0_reg);
    assign hit1    = moving && cctl1_reg[dct_pkg::CCTL_EN_BIT] && (step == cc1_reg);
    assign at_zero = moving && (step == 8'h00);
    assign at_top  = moving && (step == dct_pkg::COUNT_TOP);

    assign ovf_ev[t]         = moving && ovf_step;
    assign cmp_ev[2*t]       = hit0;
    assign cmp_ev[2*t+1]     = hit1;
    assign chf_ev[2*t]       = (mode == dct_pkg::DCT_MODE_UPDOWN) ? (moving && ovf_step) : hit0;
    assign chf_ev[2*t+1]     = hit1;

    // Masked events, plus a mask newly set over a pending flag
    assign cpu_set[t] =
      (ovf_ev[t] && ctl_reg[dct_pkg::CTL_OVERFLOW_IRQ_MASK_BIT]) ||
      (chf_ev[2*t] && cctl0_reg[dct_pkg::CCTL_IM_BIT]) ||
      (chf_ev[2*t+1] && cctl1_reg[dct_pkg::CCTL_IM_BIT]) ||
      (wr_ctl && sfr_req.wdata[dct_pkg::CTL_OVERFLOW_IRQ_MASK_BIT] && !ctl_reg[dct_pkg::CTL_OVERFLOW_IRQ_MASK_BIT] &&
       flags_reg[dct_pkg::FLAG_OVF_LSB + t]) ||
      (wr_cctl0 && sfr_req.wdata[dct_pkg::CCTL_IM_BIT] && !cctl0_reg[dct_pkg::CCTL_IM_BIT] &&
       flags_reg[dct_pkg::FLAG_CH_LSB + 2*t]) ||
      (wr_cctl1 && sfr_req.wdata[dct_pkg::CCTL_IM_BIT] && !cctl1_reg[dct_pkg::CCTL_IM_BIT] &&
       flags_reg[dct_pkg::FLAG_CH_LSB + 2*t + 1]);

    always_comb
    begin
      cnt_next = cnt_reg;
      dir_next = dir_reg;
      if (clr_req)
      begin
        cnt_next = dct_pkg::COUNT_RESET;
        dir_next = 1'b0;
      end
      else if (start_rise &&
               (sfr_req.wdata[dct_pkg::CTL_MODE_LSB +: 2] == dct_pkg::DCT_MODE_DOWN))
        cnt_next = cc0_reg;
      else if (act_edge)
      begin
        cnt_next = step;
        dir_next = step_dir;
      end
    end

    assign out_next[0] = dct_action_next(cctl0_reg[dct_pkg::CCTL_CMP_LSB +: 3], out_reg[0],
                                         hit0, stepped_down, at_zero, at_top);
    assign out_next[1] = dct_action_next(cctl1_reg[dct_pkg::CCTL_CMP_LSB +: 3], out_reg[1],
                                         hit1, stepped_down, at_zero, at_top);

    // Registered pin levels avoid decode glitches on the pads
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
      if (!rst_n)
      begin
        ctl_reg      <= dct_pkg::CONTROL_RESET;
        cctl0_reg    <= dct_pkg::CH_CTL_RESET;
        cctl1_reg    <= dct_pkg::CH_CTL_RESET;
        cc0_reg      <= dct_pkg::CMP_RESET;
        cc1_reg      <= dct_pkg::CMP_RESET;
        cc1_pend_reg <= dct_pkg::CMP_RESET;
        cnt_reg      <= dct_pkg::COUNT_RESET;
        dir_reg      <= 1'b0;
        out_reg      <= 2'b00;
        dma_reg      <= 2'b00;
      end
      else if (clk_en)
      begin
        ctl_reg   <= ctl_next;
        cctl0_reg <= wr_cctl0 ? (sfr_req.wdata & 8'h7c) : cctl0_reg;
        cctl1_reg <= wr_cctl1 ? (sfr_req.wdata & 8'h7c) : cctl1_reg;
        cc0_reg   <= wr_cc0 ? sfr_req.wdata : cc0_reg;
        cc1_pend_reg <= wr_cc1 ? sfr_req.wdata : cc1_pend_reg;
        // Pending channel 1 value lands only while the count sits at zero
        if (cnt_reg == 8'h00)
          cc1_reg <= wr_cc1 ? sfr_req.wdata : cc1_pend_reg;
        cnt_reg <= cnt_next;
        dir_reg <= dir_next;
        out_reg <= out_next;
        dma_reg <= cmp_ev[2*t +: 2];
      end
    end

    assign rd_val[t] =
      dct_hit(sfr_req.addr, BASE, dct_pkg::OFF_COUNT)   ? cnt_reg :
      dct_hit(sfr_req.addr, BASE, dct_pkg::OFF_CONTROL) ? ctl_reg :
      dct_hit(sfr_req.addr, BASE, dct_pkg::OFF_CH0_CTL) ? cctl0_reg :
      dct_hit(sfr_req.addr, BASE, dct_pkg::OFF_CH0_CMP) ? cc0_reg :
      dct_hit(sfr_req.addr, BASE, dct_pkg::OFF_CH1_CTL) ? cctl1_reg :
      dct_hit(sfr_req.addr, BASE, dct_pkg::OFF_CH1_CMP) ? cc1_pend_reg : 8'h00;
  end

  // ------------------------------------------------------------------
  // Shared flags, CPU flags and requests
  // ------------------------------------------------------------------
  // Hardware set wins over a software clear in the same cycle
  assign flags_next = ((flag_wr ? (flags_reg & sfr_req.wdata[5:0]) : flags_reg) |
                       {chf_ev, ovf_ev});
  assign cpu_flag_next = (cpu_flag_reg & ~cpu_flag_clear) | cpu_set;
  assign rdata_next = rd_val[0] | rd_val[1] | (flag_rd ? {2'b00, flags_reg} : 8'h00);

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flags_reg    <= dct_pkg::FLAG_RESET;
      cpu_flag_reg <= 2'b00;
      irq_reg      <= 2'b00;
      rdata_reg    <= 8'h00;
    end
    else if (clk_en)
    begin
      flags_reg    <= flags_next;
      cpu_flag_reg <= cpu_flag_next;
      irq_reg      <= cpu_flag_next & global_enable_per_timer;
      rdata_reg    <= rdata_next;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign sfr_rdata          = rdata_reg;
  assign channel_out_a      = g_tmr[0].out_reg;
  assign channel_out_b      = g_tmr[1].out_reg;
  assign dma_trig_a0        = g_tmr[0].dma_reg[0];
  assign dma_trig_a1        = g_tmr[0].dma_reg[1];
  assign dma_trig_b0        = g_tmr[1].dma_reg[0];
  assign dma_trig_b1        = g_tmr[1].dma_reg[1];
  assign cpu_flag_per_timer = cpu_flag_reg;
  assign irq_request_a      = irq_reg[0];
  assign irq_request_b      = irq_reg[1];

endmodule : dct_timer

// ### verilog/dct_pkg.sv
// Constants, types and register map of the dual 8-bit compare timer.
// Assumes a single-cycle special function register port on clk_sys.
package dct_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] TIMER3_COUNT_VALUE_ADDR = 8'hca;
  localparam logic [7:0] TIMER_B_BASE            = 8'hea;
  localparam logic [7:0] SHARED_FLAG_ADDR        = 8'hd8;
  localparam logic [7:0] OFF_COUNT               = 8'h00;
  localparam logic [7:0] OFF_CONTROL             = 8'h01;
  localparam logic [7:0] OFF_CH0_CTL             = 8'h02;
  localparam logic [7:0] OFF_CH0_CMP             = 8'h03;
  localparam logic [7:0] OFF_CH1_CTL             = 8'h04;
  localparam logic [7:0] OFF_CH1_CMP             = 8'h05;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTL_DIV_LSB   = 5;
  localparam int CTL_START_BIT = 4;
  localparam int CTL_OVERFLOW_IRQ_MASK_BIT = 3;
  localparam int CTL_CLEAR_BIT = 2;
  localparam int CTL_MODE_LSB  = 0;
  localparam int CCTL_IM_BIT   = 6;
  localparam int CCTL_CMP_LSB  = 3;
  localparam int CCTL_EN_BIT   = 2;
  localparam int FLAG_OVF_LSB  = 0;
  localparam int FLAG_CH_LSB   = 2;

  // ----------------------------------------------------------------
  // Reset values and constants
  // ----------------------------------------------------------------
  localparam logic [7:0] CONTROL_RESET = 8'h08;
  localparam logic [7:0] CH_CTL_RESET  = 8'h40;
  localparam logic [7:0] COUNT_RESET   = 8'h00;
  localparam logic [7:0] CMP_RESET     = 8'h00;
  localparam logic [5:0] FLAG_RESET    = 6'h00;
  localparam logic [7:0] COUNT_TOP     = 8'hff;
  localparam int         PRESCALE_W    = 7;
  localparam int         VECTOR_A      = 11;
  localparam int         VECTOR_B      = 12;

  typedef enum logic [1:0] {
    DCT_MODE_FREE   = 2'b00,
    DCT_MODE_DOWN   = 2'b01,
    DCT_MODE_MODULO = 2'b10,
    DCT_MODE_UPDOWN = 2'b11
  } dct_mode_t;

  typedef enum logic [2:0] {
    DCT_ACT_SET      = 3'b000,
    DCT_ACT_CLEAR    = 3'b001,
    DCT_ACT_TOGGLE   = 3'b010,
    DCT_ACT_UP_SET   = 3'b011,
    DCT_ACT_UP_CLEAR = 3'b100,
    DCT_ACT_SET_TOP  = 3'b101,
    DCT_ACT_CLR_ZERO = 3'b110,
    DCT_ACT_NONE     = 3'b111
  } dct_action_t;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic [7:0] wdata;
  } dct_sfr_req_t;

endpackage : dct_pkg

// ### verilog/dct_prescaler.sv
// Tick prescaler: one active edge every 2**div timer ticks.
// Assumes tick is a one-cycle pulse on clk_sys.
`timescale 1ns/1ps
module dct_prescaler #(
  parameter int W = dct_pkg::PRESCALE_W
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic         clk_en,
  input  wire logic         run,
  input  wire logic         tick,
  input  wire logic [2:0]   div,
  output wire logic         active_edge
);
  logic [W-1:0] pre_reg;
  logic [W:0]   mask_full;
  logic [W-1:0] mask;

  // Divider change acts at once: the mask is combinational
  assign mask_full   = ({{W{1'b0}}, 1'b1} << div) - {{W{1'b0}}, 1'b1};
  assign mask        = mask_full[W-1:0];
  assign active_edge = tick && run && ((pre_reg & mask) == mask);

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      pre_reg <= '0;
    else if (clk_en && tick && run)
      pre_reg <= pre_reg + {{(W-1){1'b0}}, 1'b1};
  end
endmodule : dct_prescaler

// ### dv/dct_timer_checker.sv
// Port-level assertions for the dual 8-bit compare timer.
// Assumes it is bound onto dct_timer; one clock domain, clk_sys.
`timescale 1ns/1ps
module dct_timer_checker (
  input wire logic                  clk_sys,
  input wire logic                  rst_n,
  input wire logic                  clk_en,
  input wire logic                  timer_tick,
  input wire dct_pkg::dct_sfr_req_t sfr_req,
  input wire logic [1:0]            global_enable_per_timer,
  input wire logic [1:0]            cpu_flag_clear,
  input wire logic [7:0]            sfr_rdata,
  input wire logic [1:0]            channel_out_a,
  input wire logic [1:0]            channel_out_b,
  input wire logic                  dma_trig_a0,
  input wire logic                  dma_trig_a1,
  input wire logic                  dma_trig_b0,
  input wire logic                  dma_trig_b1,
  input wire logic [1:0]            cpu_flag_per_timer,
  input wire logic                  irq_request_a,
  input wire logic                  irq_request_b
);
  // ----------------------------------------
  // Relations at the ports
  // ----------------------------------------
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  irq_gate_a: assert property ($past(clk_en) |-> irq_request_a ==
    (cpu_flag_per_timer[0] && $past(global_enable_per_timer[0]))) else $error("irq a not flag and enable");
  irq_gate_b_a: assert property ($past(clk_en) |-> irq_request_b ==
    (cpu_flag_per_timer[1] && $past(global_enable_per_timer[1]))) else $error("irq b not flag and enable");
  flag_sticky_a: assert property ($fell(cpu_flag_per_timer[0]) |-> $past(cpu_flag_clear[0]))
    else $error("cpu flag a fell without clear");
  flag_b_sticky_a: assert property ($fell(cpu_flag_per_timer[1]) |-> $past(cpu_flag_clear[1]))
    else $error("cpu flag b fell without clear");
  flag_cause_a: assert property ($rose(cpu_flag_per_timer[0]) |-> $past(timer_tick) || $past(sfr_req.wr))
    else $error("cpu flag a rose without tick or write");
  dma_tick_a: assert property ((dma_trig_a0 || dma_trig_a1) |-> $past(timer_tick))
    else $error("dma a without tick");
  dma_b_tick_a: assert property ((dma_trig_b0 || dma_trig_b1) |-> $past(timer_tick))
    else $error("dma b without tick");
  pins_hold_a: assert property (!$past(timer_tick) && !$past(sfr_req.wr) |-> $stable(channel_out_a))
    else $error("pin a moved without event");
  pins_b_hold_a: assert property (!$past(timer_tick) && !$past(sfr_req.wr) |-> $stable(channel_out_b))
    else $error("pin b moved without event");
  unmapped_zero_a: assert property ($past(clk_en) && $past(sfr_req.addr) == 8'h00 |-> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule : dct_timer_checker

bind dct_timer dct_timer_checker u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
  .timer_tick(timer_tick), .sfr_req(sfr_req), .global_enable_per_timer(global_enable_per_timer),
  .cpu_flag_clear(cpu_flag_clear), .sfr_rdata(sfr_rdata), .channel_out_a(channel_out_a),
  .channel_out_b(channel_out_b), .dma_trig_a0(dma_trig_a0), .dma_trig_a1(dma_trig_a1),
  .dma_trig_b0(dma_trig_b0), .dma_trig_b1(dma_trig_b1), .cpu_flag_per_timer(cpu_flag_per_timer),
  .irq_request_a(irq_request_a), .irq_request_b(irq_request_b));

// ### dv/tb_top.sv
// Self-checking bench for the dual 8-bit compare timer.
// Assumes the checker is bound onto dct_timer; inputs change at falling edges.
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {logic [1:0] kind; logic [7:0] val;} dct_note_t;
  logic                  clk_sys, rst_n, clk_en, timer_tick, look, p;
  logic                  seen = 1'b0;
  dct_pkg::dct_sfr_req_t sfr_req;
  logic [1:0]            global_enable_per_timer, cpu_flag_clear, channel_out_a, channel_out_b, cpu_flag_per_timer;
  logic [7:0]            sfr_rdata, got, r, c, b;
  logic [7:0]            dma_a0_cnt = 8'h00;
  logic [7:0]            exp_dma = 8'h00;
  logic                  dma_trig_a0, dma_trig_a1, dma_trig_b0, dma_trig_b1, irq_request_a, irq_request_b;
  dct_note_t             note_q[$];
  dct_note_t             n;
  int                    bad_count = 0;
  int                    checks_done = 0;
  int                    cycles = 0;
  // Pin level after the compare and after the wrap, per action
  localparam logic [7:0] AFTER_CMP = 8'h29;
  localparam logic [7:0] AFTER_WRAP = 8'h51;

  dct_timer dut (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .timer_tick(timer_tick), .sfr_req(sfr_req),
    .global_enable_per_timer(global_enable_per_timer), .cpu_flag_clear(cpu_flag_clear), .sfr_rdata(sfr_rdata),
    .channel_out_a(channel_out_a), .channel_out_b(channel_out_b), .dma_trig_a0(dma_trig_a0),
    .dma_trig_a1(dma_trig_a1), .dma_trig_b0(dma_trig_b0), .dma_trig_b1(dma_trig_b1),
    .cpu_flag_per_timer(cpu_flag_per_timer), .irq_request_a(irq_request_a), .irq_request_b(irq_request_b));

  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // ----------------------------------------
  // Drivers
  // ----------------------------------------
  function automatic logic [7:0] ctl(input logic [2:0] d, input logic s, m, k, input logic [1:0] md);
    return {d, s, m, k, md};
  endfunction : ctl

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    sfr_req = '{addr: a, wr: 1'b1, wdata: d};
    @(negedge clk_sys);
    sfr_req.wr = 1'b0;
  endtask : wr

  // Kind 0 read data, 1 status, 2 dma count, 3 timer A pins
  task automatic chk(input logic [1:0] k, input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_sys);
    sfr_req.addr = a;
    note_q.push_back('{kind: k, val: e});
    look = 1'b1;
    @(negedge clk_sys);
    look = 1'b0;
  endtask : chk

  task automatic ticks(input int t);
    repeat (t) @(negedge clk_sys) timer_tick = 1'b1;
    @(negedge clk_sys);
    timer_tick = 1'b0;
  endtask : ticks

  task automatic tidy();
    wr(8'hd8, 8'h00);
    @(negedge clk_sys);
    cpu_flag_clear = 2'b11;
    global_enable_per_timer = 2'b00;
    @(negedge clk_sys);
    cpu_flag_clear = 2'b00;
  endtask : tidy

  task automatic conclude();
    if (bad_count == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude

  // ----------------------------------------
  // Result watcher
  // ----------------------------------------
  always @(posedge clk_sys)
  begin
    cycles++;
    if (dma_trig_a0)
      dma_a0_cnt <= dma_a0_cnt + 8'h01;
    if (seen)
    begin
      n = note_q.pop_front();
      got = (n.kind == 2'd0) ? sfr_rdata : (n.kind == 2'd2) ? dma_a0_cnt : (n.kind == 2'd3) ? {6'h00, channel_out_a}
          : {irq_request_b, irq_request_a, cpu_flag_per_timer, channel_out_b, channel_out_a};
      checks_done++;
      if (got !== n.val)
      begin
        bad_count++;
        $display("BAD t=%0t got=%h exp=%h", $time, got, n.val);
      end
    end
    seen <= look;
    if (cycles == 20000)
    begin
      bad_count++;
      conclude();
    end
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    timer_tick = 1'b0;
    sfr_req = '0;
    global_enable_per_timer = 2'b00;
    cpu_flag_clear = 2'b00;
    look = 1'b0;
    void'($urandom(89404));
    repeat (12) @(negedge clk_sys);
    rst_n = 1'b1;
    chk(0, 8'hca, 8'h00);
    chk(0, 8'hcb, 8'h08);
    chk(0, 8'hcc, 8'h40);
    chk(0, 8'h00, 8'h00);
    wr(8'hca, 8'h55);
    chk(0, 8'hca, 8'h00);
    for (int d = 0; d < 8; d++)
    begin
      wr(8'hcb, ctl(3'(d), 1'b1, 1'b1, 1'b1, 2'b00));
      ticks(3 << d);
      wr(8'hcb, ctl(3'(d), 1'b0, 1'b1, 1'b0, 2'b00));
      chk(0, 8'hca, 8'h03);
    end
    ticks(5);
    chk(0, 8'hca, 8'h03);
    // Clock enable low: neither the write nor the ticks may land
    clk_en = 1'b0;
    wr(8'hcb, ctl(3'h0, 1'b1, 1'b1, 1'b1, 2'b00));
    ticks(5);
    clk_en = 1'b1;
    chk(0, 8'hca, 8'h03);
    for (int t = 0; t < 2; t++)
    begin
      b = (t == 0) ? 8'hca : 8'hea;
      wr(8'hd8, 8'h00);
      wr(b + 8'h01, ctl(3'h0, 1'b1, 1'b1, 1'b1, 2'b00));
      ticks(255);
      chk(0, b, 8'hff);
      chk(0, 8'hd8, (t == 0) ? 8'h01 : 8'h02);
      chk(1, 8'h00, (t == 0) ? 8'h10 : 8'h20);
      @(negedge clk_sys);
      global_enable_per_timer[t] = 1'b1;
      chk(1, 8'h00, (t == 0) ? 8'h50 : 8'ha0);
      ticks(1);
      chk(0, b, 8'h00);
      wr(b + 8'h01, ctl(3'h0, 1'b0, 1'b1, 1'b1, 2'b00));
      tidy();
    end
    wr(8'hcb, ctl(3'h0, 1'b1, 1'b0, 1'b1, 2'b00));
    ticks(255);
    chk(1, 8'h00, 8'h00);
    chk(0, 8'hd8, 8'h01);
    @(negedge clk_sys);
    global_enable_per_timer = 2'b01;
    wr(8'hcb, ctl(3'h0, 1'b0, 1'b1, 1'b1, 2'b00));
    chk(1, 8'h00, 8'h50);
    tidy();
    r = 8'($urandom_range(8'hf0, 8'h02));
    wr(8'hcd, r);
    wr(8'hcb, ctl(3'h0, 1'b1, 1'b1, 1'b1, 2'b10));
    ticks(r);
    chk(0, 8'hca, r);
    chk(0, 8'hd8, 8'h01);
    ticks(1);
    chk(0, 8'hca, 8'h00);
    wr(8'hcb, ctl(3'h0, 1'b0, 1'b1, 1'b1, 2'b01));
    wr(8'hd8, 8'h00);
    wr(8'hcb, ctl(3'h0, 1'b1, 1'b1, 1'b0, 2'b01));
    ticks(r - 1);
    chk(0, 8'hca, 8'h01);
    chk(0, 8'hd8, 8'h00);
    ticks(3);
    chk(0, 8'hca, 8'h00);
    chk(0, 8'hd8, 8'h01);
    wr(8'hcb, ctl(3'h0, 1'b0, 1'b1, 1'b1, 2'b11));
    wr(8'hcc, 8'h14);
    wr(8'hd8, 8'h00);
    wr(8'hcb, ctl(3'h0, 1'b1, 1'b1, 1'b1, 2'b11));
    ticks(r);
    chk(0, 8'hca, r);
    chk(0, 8'hd8, 8'h00);
    ticks(r);
    chk(0, 8'hca, 8'h00);
    chk(0, 8'hd8, 8'h05);
    exp_dma = exp_dma + 8'h01;
    wr(8'hcb, ctl(3'h0, 1'b0, 1'b1, 1'b1, 2'b00));
    wr(8'hcf, 8'h80);
    p = 1'b1;
    for (int act = 0; act < 8; act++)
    begin
      c = 8'($urandom_range(8'hfd, 8'h02));
      wr(8'hcd, c);
      wr(8'hcc, {2'b00, 3'(act), 3'b100});
      wr(8'hcb, ctl(3'h0, 1'b1, 1'b1, 1'b1, 2'b00));
      ticks(c);
      p = (act == 7) ? p : (act == 2) ? !p : AFTER_CMP[act];
      chk(3, 8'h00, {7'h00, p});
      ticks(256 - c);
      p = (act == 2 || act == 7) ? p : AFTER_WRAP[act];
      chk(3, 8'h00, {7'h00, p});
      wr(8'hcb, ctl(3'h0, 1'b0, 1'b1, 1'b0, 2'b00));
      exp_dma = exp_dma + 8'h01;
    end
    // Compare moved above the short run so a small random value cannot match
    wr(8'hcd, 8'h10);
    wr(8'hcb, ctl(3'h0, 1'b1, 1'b1, 1'b1, 2'b00));
    ticks(5);
    wr(8'hcb, ctl(3'h0, 1'b0, 1'b1, 1'b0, 2'b00));
    wr(8'hcc, 8'h4c);
    wr(8'hce, 8'h04);
    wr(8'hcf, 8'h10);
    tidy();
    wr(8'hcb, ctl(3'h0, 1'b1, 1'b1, 1'b0, 2'b00));
    ticks(11);
    chk(3, 8'h00, 8'h00);
    chk(1, 8'h00, 8'h10);
    exp_dma = exp_dma + 8'h01;
    chk(2, 8'h00, exp_dma);
    conclude();
  end
endmodule : tb_top
